// file: rtl/csh_pkg.sv
// constants for the camera settings housekeeping block
package csh_pkg;
  // register word offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FAN = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RPM = 8'h0C;
  localparam logic [7:0] ADDR_WORK0 = 8'h10;
  localparam logic [7:0] ADDR_WORK1 = 8'h14;
  localparam logic [7:0] ADDR_LABEL0 = 8'h20;
  localparam logic [7:0] ADDR_TEMP = 8'h30;
  // ctrl fields
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_START_LSB = 4;
  localparam int CTRL_LOAD_BIT = 8;
  localparam int CTRL_SAVE_BIT = 9;
  localparam int CTRL_RESTART_BIT = 16;
  // fan fields
  localparam int FAN_MODE_LSB = 0;
  localparam int FAN_THR_LSB = 8;
  // set codes
  localparam logic [1:0] SET_FACTORY = 2'h0;
  localparam logic [1:0] SET_A = 2'h1;
  localparam logic [1:0] SET_B = 2'h2;
  // fan modes
  localparam logic [1:0] FAN_OFF = 2'h0;
  localparam logic [1:0] FAN_ON = 2'h1;
  localparam logic [1:0] FAN_TEMP = 2'h2;
  // threshold limits, signed degrees C
  localparam logic signed [7:0] THR_MIN = -8'sd10;
  localparam logic signed [7:0] THR_MAX = 8'sd80;
  localparam logic signed [7:0] THR_RESET = 8'sd40;
  // settings set: two 32-bit words, factory content arbitrary
  localparam int SET_WORDS = 2;
  localparam logic [31:0] FACTORY_W0 = 32'h0000_0000;
  localparam logic [31:0] FACTORY_W1 = 32'h0000_0000;
  localparam int LABEL_WORDS = 4;
  // restart pulse length
  localparam int RESTART_NS = 1000;
  localparam int CLK_NS = 8;
  localparam int RESTART_CYC = (RESTART_NS + CLK_NS - 1) / CLK_NS;
  // rpm: tach pulses counted over one second window, two pulses per turn
  localparam int RPM_WINDOW_CYC = 125000000;
  localparam int TACH_PER_REV = 2;
endpackage

// file: rtl/csh_store.sv
// small memory holding the two saveable settings sets, registered read
`timescale 1ns/1ps
`default_nettype none
module csh_store
(
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [1:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o
);
  logic [31:0] mem [0:3];
  logic [31:0] rdata;

  // no reset: contents stand for nonvolatile storage
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[addr_i] <= wdata_i;
    end
    rdata <= mem[addr_i];
  end

  assign rdata_o = rdata;
endmodule
`default_nettype wire

// file: rtl/csh_top.sv
// housekeeping: settings sets, fan control, label store, restart
//
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module csh_top
#(
  parameter int RPM_WINDOW = csh_pkg::RPM_WINDOW_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic tach_i,
  input wire logic signed [7:0] temp_i,
  output logic fan_on_o,
  output logic full_restart_o,
  output logic [31:0] work0_o,
  output logic [31:0] work1_o
);
  typedef enum logic [2:0] {CSH_IDLE, CSH_RD, CSH_RD_W0, CSH_RD_W1, CSH_WR1} csh_state_e;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  csh_state_e state, next_state;
  logic ack, next_ack;
  logic [31:0] dat, next_dat;
  logic [1:0] set_sel, next_set_sel;
  logic [1:0] start_sel, next_start_sel;
  logic [1:0] fan_mode, next_fan_mode;
  logic signed [7:0] thr, next_thr;
  logic [31:0] work [0:1];
  logic [31:0] next_work [0:1];
  logic [31:0] label [0:3];
  logic [31:0] next_label [0:3];
  logic [1:0] op_set, next_op_set;
  logic restart, next_restart;
  logic [7:0] rst_cnt, next_rst_cnt;
  logic mem_we;
  logic [1:0] mem_addr;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rdata;
  logic access;
  logic [2:0] tach_sync;
  logic tach_q, next_tach_q;
  logic [31:0] win, next_win;
  logic [15:0] pulses, next_pulses;
  logic [15:0] rpm, next_rpm;
  logic fan_on, next_fan_on;

  assign access = cyc_i && stb_i && !ack;

  // ----------------------------------------------------------------
  // saved sets: word address = {set b?, word}
  // ----------------------------------------------------------------
  csh_store u_store
  (
    .clk_i(clk_i),
    .we_i(mem_we),
    .addr_i(mem_addr),
    .wdata_i(mem_wdata),
    .rdata_o(mem_rdata)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  // ----------------------------------------------------------------
  // bus, load, save, reset-time apply
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [31:0] w;
    logic signed [7:0] t;
    w = merge(32'h0000_0000, dat_i, sel_i);
    t = $signed(w[csh_pkg::FAN_THR_LSB +: 8]);
    next_state = state;
    next_ack = 1'b0;
    next_dat = dat;
    next_set_sel = set_sel;
    next_start_sel = start_sel;
    next_fan_mode = fan_mode;
    next_thr = thr;
    next_op_set = op_set;
    next_restart = restart;
    next_rst_cnt = rst_cnt;
    next_work = work;
    next_label = label;
    mem_we = 1'b0;
    mem_addr = {op_set == csh_pkg::SET_B, 1'b0};
    mem_wdata = work[0];
    // hold until the counter runs out, then drop the pulse
    if (restart && rst_cnt == 8'h00)
      next_restart = 1'b0;
    else if (restart)
      next_rst_cnt = rst_cnt - 8'h01;
    case (state)
      CSH_IDLE:
      begin
        if (access && we_i)
        begin
          next_ack = 1'b1;
          if (adr_i == csh_pkg::ADDR_CTRL)
          begin
            if (sel_i[0])
            begin
              if (w[csh_pkg::CTRL_SEL_LSB +: 2] <= csh_pkg::SET_B)
                next_set_sel = w[csh_pkg::CTRL_SEL_LSB +: 2];
              if (w[csh_pkg::CTRL_START_LSB +: 2] <= csh_pkg::SET_B)
                next_start_sel = w[csh_pkg::CTRL_START_LSB +: 2];
            end
            if (w[csh_pkg::CTRL_LOAD_BIT])
            begin
              next_op_set = set_sel;
              if (set_sel == csh_pkg::SET_FACTORY)
              begin
                next_work[0] = csh_pkg::FACTORY_W0;
                next_work[1] = csh_pkg::FACTORY_W1;
              end
              else
              begin
                next_ack = 1'b0;
                next_state = CSH_RD;
              end
            end
            else if (w[csh_pkg::CTRL_SAVE_BIT] && set_sel != csh_pkg::SET_FACTORY)
            begin
              mem_we = 1'b1;
              mem_addr = {set_sel == csh_pkg::SET_B, 1'b0};
              next_op_set = set_sel;
              next_ack = 1'b0;
              next_state = CSH_WR1;
            end
            if (w[csh_pkg::CTRL_RESTART_BIT])
            begin
              next_restart = 1'b1;
              next_rst_cnt = 8'(csh_pkg::RESTART_CYC - 1);
            end
          end
          else if (adr_i == csh_pkg::ADDR_FAN)
          begin
            if (sel_i[0] && w[1:0] <= csh_pkg::FAN_TEMP)
              next_fan_mode = w[csh_pkg::FAN_MODE_LSB +: 2];
            if (sel_i[1] && t >= csh_pkg::THR_MIN && t <= csh_pkg::THR_MAX)
              next_thr = t;
          end
          else if (adr_i == csh_pkg::ADDR_WORK0 || adr_i == csh_pkg::ADDR_WORK1)
          begin
            next_work[adr_i[2]] = merge(work[adr_i[2]], dat_i, sel_i);
          end
          else if (adr_i[7:4] == csh_pkg::ADDR_LABEL0[7:4])
          begin
            next_label[adr_i[3:2]] = merge(label[adr_i[3:2]], dat_i, sel_i);
          end
        end
        else if (access)
        begin
          next_ack = 1'b1;
          next_dat = 32'h0000_0000;
          if (adr_i == csh_pkg::ADDR_CTRL)
            next_dat = {26'h000_0000, start_sel, 2'h0, set_sel};
          else if (adr_i == csh_pkg::ADDR_FAN)
            next_dat = {16'h0000, thr, 6'h00, fan_mode};
          else if (adr_i == csh_pkg::ADDR_STATUS)
            next_dat = {31'h0000_0000, fan_on_o};
          else if (adr_i == csh_pkg::ADDR_RPM)
            next_dat = {16'h0000, rpm};
          else if (adr_i == csh_pkg::ADDR_TEMP)
            next_dat = {24'h00_0000, temp_i};
          else if (adr_i == csh_pkg::ADDR_WORK0 || adr_i == csh_pkg::ADDR_WORK1)
            next_dat = work[adr_i[2]];
          else if (adr_i[7:4] == csh_pkg::ADDR_LABEL0[7:4])
            next_dat = label[adr_i[3:2]];
        end
      end
      CSH_RD:
      begin
        // registered read: word 0 now, word 1 next cycle
        mem_addr = {op_set == csh_pkg::SET_B, 1'b0};
        next_state = CSH_RD_W0;
      end
      CSH_RD_W0:
      begin
        next_work[0] = mem_rdata;
        mem_addr = {op_set == csh_pkg::SET_B, 1'b1};
        next_state = CSH_RD_W1;
      end
      CSH_RD_W1:
      begin
        next_work[1] = mem_rdata;
        next_ack = cyc_i && stb_i && we_i;
        next_state = CSH_IDLE;
      end
      CSH_WR1:
      begin
        mem_we = 1'b1;
        mem_addr = {op_set == csh_pkg::SET_B, 1'b1};
        mem_wdata = work[1];
        next_ack = cyc_i && stb_i;
        next_state = CSH_IDLE;
      end
      default:
      begin
        next_state = CSH_IDLE;
      end
    endcase
  end

  // reset applies the startup set: factory directly, saved sets by a load
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack <= 1'b0;
      dat <= 32'h0000_0000;
      set_sel <= csh_pkg::SET_FACTORY;
      fan_mode <= csh_pkg::FAN_OFF;
      thr <= csh_pkg::THR_RESET;
      restart <= 1'b0;
      rst_cnt <= 8'h00;
      work <= '{csh_pkg::FACTORY_W0, csh_pkg::FACTORY_W1};
      op_set <= start_sel;
      state <= (start_sel == csh_pkg::SET_FACTORY) ? CSH_IDLE : CSH_RD;
      label <= '{default: 32'h0000_0000};
    end
    else
    begin
      ack <= next_ack;
      dat <= next_dat;
      set_sel <= next_set_sel;
      fan_mode <= next_fan_mode;
      thr <= next_thr;
      restart <= next_restart;
      rst_cnt <= next_rst_cnt;
      work <= next_work;
      op_set <= next_op_set;
      state <= next_state;
      label <= next_label;
    end
  end

  // startup choice is kept like saved data: it survives reset
  always_ff @(posedge clk_i)
  begin
    start_sel <= next_start_sel;
  end

  // ----------------------------------------------------------------
  // fan control and tachometer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    tach_sync <= {tach_sync[1:0], tach_i};
  end

  always_comb
  begin
    next_tach_q = tach_q;
    if (tach_sync[1] == tach_sync[2])
      next_tach_q = tach_sync[2];
    next_pulses = pulses + {15'h0000, (next_tach_q && !tach_q)};
    next_win = win + 32'h0000_0001;
    next_rpm = rpm;
    if (win == 32'(RPM_WINDOW - 1))
    begin
      // pulses per second times sixty over pulses per turn
      next_rpm = 16'((32'(pulses) * 60) / csh_pkg::TACH_PER_REV);
      next_pulses = 16'h0000;
      next_win = 32'h0000_0000;
    end
    case (fan_mode)
      csh_pkg::FAN_ON: next_fan_on = 1'b1;
      csh_pkg::FAN_TEMP: next_fan_on = (temp_i > thr);
      default: next_fan_on = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tach_q <= 1'b0;
      win <= 32'h0000_0000;
      pulses <= 16'h0000;
      rpm <= 16'h0000;
      fan_on <= 1'b0;
    end
    else
    begin
      tach_q <= next_tach_q;
      win <= next_win;
      pulses <= next_pulses;
      rpm <= next_rpm;
      fan_on <= next_fan_on;
    end
  end

  assign dat_o = dat;
  assign ack_o = ack;
  assign fan_on_o = fan_on;
  assign full_restart_o = restart;
  assign work0_o = work[0];
  assign work1_o = work[1];
endmodule
`default_nettype wire

// file: dv/csh_fan_model.sv
// fan model: spins and gives tach pulses only while driven
`timescale 1ns/1ps
`default_nettype none
module csh_fan_model
(
  input wire logic clk_i,
  input wire logic fan_on_i,
  output logic tach_o
);
  logic [3:0] ph = 4'h0;
  // fixed ten-cycle period keeps the pulse count per window exact
  always_ff @(posedge clk_i)
  begin
    ph <= (ph == 4'h9 || !fan_on_i) ? 4'h0 : ph + 4'h1;
    tach_o <= fan_on_i && ph < 4'h5;
  end
endmodule
`default_nettype wire

// file: dv/csh_top_properties.sv
// port assertions for the housekeeping block
`timescale 1ns/1ps
`default_nettype none
module csh_top_properties
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic fan_on_o,
  input wire logic full_restart_o,
  input wire logic [31:0] work0_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // cycles since reset release, saturating
  // ----------------------------------------
  logic [2:0] since_rst;
  logic [2:0] next_since_rst;
  always_comb
  begin
    next_since_rst = (since_rst == 3'h7) ? 3'h7 : since_rst + 3'h1;
    if (rst_i)
      next_since_rst = 3'h0;
  end
  always_ff @(posedge clk_i)
  begin
    since_rst <= next_since_rst;
  end
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  reset_quiet_a: assert property ($fell(rst_i) |-> !fan_on_o && !ack_o && !full_restart_o)
    else $error("outputs active out of reset");
  reset_work_a: assert property ($fell(rst_i) |-> work0_o == 32'h0000_0000)
    else $error("working settings survive reset");
  restart_len_a: assert property ($rose(full_restart_o) |-> ##124 full_restart_o ##1 !full_restart_o)
    else $error("restart pulse length wrong");
  restart_hold_a: assert property ($rose(full_restart_o) |-> full_restart_o [*8])
    else $error("restart pulse broken");
  rdata_hold_a: assert property ($changed(dat_o) |-> ack_o)
    else $error("read data moved without ack");
  work_change_a: assert property ($changed(work0_o) && since_rst == 3'h7 |-> cyc_i)
    else $error("working settings moved unasked");
endmodule
bind csh_top csh_top_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .fan_on_o(fan_on_o),
  .full_restart_o(full_restart_o), .work0_o(work0_o));
`default_nettype wire

// file: dv/tb_csh_top.sv
// self-checking bench for the housekeeping block
`timescale 1ns/1ps
`default_nettype none
module tb_csh_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic signed [7:0] temp_i = 8'sd20;
  logic [31:0] dat_o, work0_o, work1_o, rd;
  logic ack_o, fan_on_o, full_restart_o, tach_i;
  int num_errors = 0;
  int checks_done = 0;
  logic [31:0] rnd = 32'hd1e2_90c7;
  logic [31:0] lab [4];
  logic [31:0] s [3][2] = '{default: 32'h0000_0000};
  logic signed [7:0] tv [4] = '{-8'sd10, 8'sd80, 8'sd81, -8'sd11};
  logic signed [7:0] thr = 8'sd40;
  always #4 clk_i = ~clk_i;
  csh_top #(.RPM_WINDOW(100)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .tach_i(tach_i), .temp_i(temp_i),
    .fan_on_o(fan_on_o), .full_restart_o(full_restart_o), .work0_o(work0_o),
    .work1_o(work1_o));
  csh_fan_model u_fan (.clk_i(clk_i), .fan_on_i(fan_on_o), .tach_o(tach_i));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // one classic cycle; entered just after a rising edge
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= wr;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 50);
    if (n >= 50)
      num_errors++;
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic reset_dut();
    rst_i <= 1'b1;
    idle(10);
    rst_i <= 1'b0;
    idle(5);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #100000;
    num_errors++;
    summarize();
  end
  initial
  begin
    int i;
    int k;
    reset_dut();
    for (i = 0; i < 8; i++)
    begin
      k = i % 4;
      if (i < 4)
      begin
        rnd = lfsr(rnd);
        lab[k] = rnd;
      end
      wb(i < 4, csh_pkg::ADDR_LABEL0 + 8'(4 * k), lab[k]);
      if (i >= 4)
        check(rd, lab[k]);
    end
    $display("label test done");
    // saves to a, b, then one aimed at the factory set
    for (i = 0; i < 3; i++)
    begin
      k = (i + 1) % 3;
      rnd = lfsr(rnd);
      wb(1'b1, csh_pkg::ADDR_WORK0, rnd);
      if (k != 0)
        s[k][0] = rnd;
      rnd = lfsr(rnd);
      wb(1'b1, csh_pkg::ADDR_WORK1, rnd);
      if (k != 0)
        s[k][1] = rnd;
      wb(1'b1, csh_pkg::ADDR_CTRL, k);
      wb(1'b1, csh_pkg::ADDR_CTRL, 32'h0000_0200 | k);
    end
    for (i = 0; i < 3; i++)
    begin
      wb(1'b1, csh_pkg::ADDR_CTRL, i);
      wb(1'b1, csh_pkg::ADDR_CTRL, 32'h0000_0100 | i);
      check(work0_o, s[i][0]);
      check(work1_o, s[i][1]);
      wb(1'b0, csh_pkg::ADDR_WORK0, 32'h0000_0000);
      check(rd, s[i][0]);
    end
    wb(1'b1, csh_pkg::ADDR_CTRL, 32'h0000_0020);
    wb(1'b1, csh_pkg::ADDR_WORK0, lfsr(rnd));
    reset_dut();
    check(work0_o, s[2][0]);
    check(work1_o, s[2][1]);
    wb(1'b0, csh_pkg::ADDR_CTRL, 32'h0000_0000);
    check(rd, 32'h0000_0020);
    $display("settings test done");
    wb(1'b1, csh_pkg::ADDR_FAN, 32'h0000_2800 | csh_pkg::FAN_ON);
    idle(250);
    check(fan_on_o, 1'b1);
    wb(1'b1, csh_pkg::ADDR_RPM, 32'h0000_1234);
    wb(1'b0, csh_pkg::ADDR_RPM, 32'h0000_0000);
    check(rd & 32'h0000_ffff, 32'h0000_012c);
    wb(1'b1, csh_pkg::ADDR_FAN, 32'h0000_2800 | csh_pkg::FAN_OFF);
    idle(250);
    check(fan_on_o, 1'b0);
    wb(1'b0, csh_pkg::ADDR_RPM, 32'h0000_0000);
    check(rd & 32'h0000_ffff, 32'h0000_0000);
    for (i = 0; i < 4; i++)
    begin
      wb(1'b1, csh_pkg::ADDR_FAN, {16'h0000, tv[i], 8'h02});
      if (tv[i] >= csh_pkg::THR_MIN && tv[i] <= csh_pkg::THR_MAX)
        thr = tv[i];
      wb(1'b1, csh_pkg::ADDR_FAN, {16'h0000, thr, 8'h03});
      wb(1'b0, csh_pkg::ADDR_FAN, 32'h0000_0000);
      check(rd & 32'h0000_ffff, {16'h0000, thr, 8'h02});
      temp_i <= thr;
      idle(4);
      check(fan_on_o, 1'b0);
      temp_i <= thr + 8'sd1;
      idle(4);
      check(fan_on_o, 1'b1);
    end
    wb(1'b0, csh_pkg::ADDR_TEMP, 32'h0000_0000);
    check(rd[7:0], temp_i);
    wb(1'b1, 8'h40, 32'hffff_ffff);
    wb(1'b0, 8'h40, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    $display("fan test done");
    wb(1'b1, csh_pkg::ADDR_CTRL, 32'h0001_0000);
    idle(2);
    check(full_restart_o, 1'b1);
    idle(130);
    check(full_restart_o, 1'b0);
    // host sets its link up again before further access
    reset_dut();
    wb(1'b0, csh_pkg::ADDR_FAN, 32'h0000_0000);
    check(rd, 32'h0000_2800);
    $display("restart test done");
    summarize();
  end
endmodule
`default_nettype wire
